//--- core/run_ctrl_pkg.sv
package run_ctrl_pkg;

  // Timing of the evaluation step.
  localparam int CLK_PERIOD_NS = 25;
  localparam int CTRL_CYCLE_NS = 1000;
  localparam int CYCLE_CLKS =
    (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CNT_W = 8;

  // Register bus.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_AUX = 4'h8;

  // Control register field positions.
  localparam int CTRL_CYCLE_START = 0;
  localparam int CTRL_FORCED_END = 1;
  localparam int CTRL_PAUSE = 2;
  localparam int CTRL_AUTO_MODE = 3;
  localparam int CTRL_SINGLE_BLOCK = 4;
  localparam int CTRL_CODE_RESET = 5;
  localparam int CTRL_ERR_RESET = 6;
  localparam int CTRL_ORIGIN = 7;
  localparam int CTRL_JOG = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // Status register field positions.
  localparam int STAT_RUNNING = 0;
  localparam int STAT_PAUSED = 1;
  localparam int STAT_AUX_WAIT = 2;
  localparam int STAT_ERROR = 3;
  localparam int STAT_MANUAL = 4;
  localparam int STAT_BUSY = 5;
  localparam int STAT_JOG_OK = 6;
  localparam int STAT_DECEL = 7;
  localparam int STAT_W = 8;

  localparam int AUX_W = 8;
  localparam logic [AUX_W-1:0] AUX_RESET = 8'h00;

  // Host control bits, packed in control register order.
  typedef struct packed {
    logic jog;
    logic origin;
    logic err_reset;
    logic code_reset;
    logic single_block;
    logic auto_mode;
    logic pause;
    logic forced_end;
    logic cycle_start;
  } ctrl_bits_t;

  // Kinds of block that the program sequencer presents.
  typedef enum logic [2:0] {
    BLK_MOTION,
    BLK_AUX_CODE,
    BLK_OPTIONAL_SKIP_FUNCTION,
    BLK_OPTIONAL_PROGRAM_STOP_FUNCTION,
    BLK_OPTIONAL_END_FUNCTION,
    BLK_WAITING_COMMAND,
    BLK_PROGRAM_END
  } blk_kind_t;

  typedef struct packed {
    logic valid;
    blk_kind_t kind;
    logic [AUX_W-1:0] code;
  } blk_in_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_RUN,
    ST_AUX_WAIT,
    ST_PAUSED,
    ST_DECEL,
    ST_MANUAL,
    ST_ORIGIN
  } run_state_t;

endpackage

//--- core/ctrl_sampler.sv
`timescale 1ns/1ps
module ctrl_sampler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input run_ctrl_pkg::ctrl_bits_t bits,
  output run_ctrl_pkg::ctrl_bits_t now,
  output run_ctrl_pkg::ctrl_bits_t rise,
  output run_ctrl_pkg::ctrl_bits_t fall,
  output logic eval
);
  import run_ctrl_pkg::*;

  ctrl_bits_t cur_r;
  ctrl_bits_t prv_r;
  logic eval_r;

  // The previous sample is kept so that edges last one evaluation only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_r <= ctrl_bits_t'(CTRL_RESET);
      prv_r <= ctrl_bits_t'(CTRL_RESET);
    end else if (tick) begin
      prv_r <= cur_r;
      cur_r <= bits;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eval_r <= 1'b0;
    end else begin
      eval_r <= tick;
    end
  end

  assign now = cur_r;
  assign rise = ctrl_bits_t'(cur_r & ~prv_r);
  assign fall = ctrl_bits_t'(~cur_r & prv_r);
  assign eval = eval_r;
endmodule

//--- core/run_ctrl.sv
`timescale 1ns/1ps
module run_ctrl #(
  parameter int CYCLE_LEN = run_ctrl_pkg::CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [run_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [run_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [run_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic opt_in,
  input run_ctrl_pkg::blk_in_t blk,
  input wire logic blk_done,
  input wire logic axes_at_rest,
  input wire logic origin_done,
  input wire logic task_fault,
  output logic blk_take,
  output logic blk_go,
  output logic blk_abort,
  output logic axis_stop,
  output logic [run_ctrl_pkg::AUX_W-1:0] aux_code,
  output logic aux_valid,
  output logic busy,
  output logic manual_flag,
  output logic jog_enable,
  output logic running
);
  import run_ctrl_pkg::*;

  localparam logic [CYCLE_CNT_W-1:0] CYC_LAST =
    CYCLE_CNT_W'(CYCLE_LEN - 1);

  logic [CYCLE_CNT_W-1:0] cnt_r;
  logic tick_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rdata_r;
  logic opt_s1_r, opt_s2_r, opt_s3_r, opt_r;
  ctrl_bits_t cur, ed_rise, ed_fall;
  logic eval;
  run_state_t state_r, state_nxt, ret_r, ret_nxt;
  logic err_r, skip_r, end_r, pend_r;
  logic [AUX_W-1:0] aux_r;
  logic aux_valid_r, busy_r, manual_r, jog_r, running_r;
  logic take_r, go_r, abort_r, stop_r;
  logic take_nxt, go_nxt, abort_nxt, stop_nxt;
  logic aux_load, aux_clear, skip_set, skip_clr, end_set, end_clr;
  logic pend_set, pend_clr, busy_set, busy_clr;
  logic start_ok, resume_ok;

  // Free-running divider that marks one evaluation per control cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == CYC_LAST) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // The optional input is a pin; a change counts when stages two and
  // three agree, which also filters a one-clock glitch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opt_s1_r <= 1'b0;
      opt_s2_r <= 1'b0;
      opt_s3_r <= 1'b0;
      opt_r <= 1'b0;
    end else begin
      opt_s1_r <= opt_in;
      opt_s2_r <= opt_s1_r;
      opt_s3_r <= opt_s2_r;
      if (opt_s2_r == opt_s3_r) begin
        opt_r <= opt_s3_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr && addr == ADDR_CTRL) begin
      ctrl_r <= wdata[CTRL_W-1:0];
    end
  end

  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] a
  );
    logic [STAT_W-1:0] st;
    st = '0;
    st[STAT_RUNNING] = running_r;
    st[STAT_PAUSED] = (state_r == ST_PAUSED);
    st[STAT_AUX_WAIT] = (state_r == ST_AUX_WAIT);
    st[STAT_ERROR] = err_r;
    st[STAT_MANUAL] = manual_r;
    st[STAT_BUSY] = busy_r;
    st[STAT_JOG_OK] = jog_r;
    st[STAT_DECEL] = (state_r == ST_DECEL);
    if (a == ADDR_CTRL) begin
      read_word = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
    end else if (a == ADDR_STATUS) begin
      read_word = {{(DATA_W-STAT_W){1'b0}}, st};
    end else if (a == ADDR_AUX) begin
      read_word = {{(DATA_W-AUX_W){1'b0}}, aux_r};
    end else begin
      read_word = '0;
    end
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (rd) begin
      rdata_r <= read_word(addr);
    end else begin
      rdata_r <= '0;
    end
  end

  ctrl_sampler u_sampler (
    .clk(clk),
    .rstn(rstn),
    .tick(tick_r),
    .bits(ctrl_bits_t'(ctrl_r)),
    .now(cur),
    .rise(ed_rise),
    .fall(ed_fall),
    .eval(eval)
  );

  // A start is only an edge, so a start held through a blocked attempt
  // must be dropped and raised again by the host.
  always_comb begin
    start_ok = ed_rise.cycle_start && !cur.forced_end && !cur.pause &&
               (!err_r || ed_rise.err_reset);
    resume_ok = ed_rise.cycle_start && !cur.pause &&
                (!err_r || ed_rise.err_reset);
  end

  always_comb begin
    state_nxt = state_r;
    ret_nxt = ret_r;
    take_nxt = 1'b0;
    go_nxt = 1'b0;
    abort_nxt = 1'b0;
    stop_nxt = 1'b0;
    aux_load = 1'b0;
    aux_clear = 1'b0;
    skip_set = 1'b0;
    skip_clr = 1'b0;
    end_set = 1'b0;
    end_clr = 1'b0;
    pend_set = 1'b0;
    pend_clr = 1'b0;
    busy_set = 1'b0;
    busy_clr = 1'b0;
    if (eval) begin
      unique case (state_r)
        ST_IDLE: begin
          if (!cur.auto_mode) begin
            state_nxt = ST_MANUAL;
          end else if (start_ok) begin
            state_nxt = ST_FETCH;
          end
        end
        ST_FETCH: begin
          // Every way from a run to manual goes through deceleration, so the
          // manual flag never rises from a run ahead of the axes.
          if (!cur.auto_mode) begin
            stop_nxt = 1'b1;
            state_nxt = ST_DECEL;
          end else if (ed_fall.cycle_start) begin
            state_nxt = ST_IDLE;
          end else if (cur.forced_end || err_r) begin
            abort_nxt = 1'b1;
            aux_clear = 1'b1;
            state_nxt = ST_IDLE;
          end else if (cur.pause) begin
            ret_nxt = ST_FETCH;
            state_nxt = ST_PAUSED;
          end else if (blk.valid) begin
            take_nxt = 1'b1;
            if (skip_r) begin
              skip_clr = 1'b1;
            end else begin
              unique case (blk.kind)
                BLK_MOTION, BLK_WAITING_COMMAND: begin
                  go_nxt = 1'b1;
                  state_nxt = ST_RUN;
                end
                BLK_AUX_CODE: begin
                  if (!cur.code_reset) begin
                    aux_load = 1'b1;
                    state_nxt = ST_AUX_WAIT;
                  end
                end
                BLK_OPTIONAL_SKIP_FUNCTION: begin
                  skip_set = opt_r;
                end
                BLK_OPTIONAL_PROGRAM_STOP_FUNCTION: begin
                  if (opt_r) begin
                    state_nxt = ST_IDLE;
                  end
                end
                BLK_OPTIONAL_END_FUNCTION: begin
                  end_set = 1'b1;
                end
                BLK_PROGRAM_END: begin
                  state_nxt = ST_IDLE;
                end
                default: begin
                  state_nxt = ST_IDLE;
                end
              endcase
            end
          end
        end
        ST_RUN: begin
          if (!cur.auto_mode) begin
            stop_nxt = 1'b1;
            pend_clr = 1'b1;
            state_nxt = ST_DECEL;
          end else if (blk_done && (pend_r || ed_fall.cycle_start)) begin
            pend_clr = 1'b1;
            end_clr = 1'b1;
            state_nxt = ST_IDLE;
          end else if (cur.forced_end || err_r) begin
            abort_nxt = 1'b1;
            aux_clear = 1'b1;
            pend_clr = 1'b1;
            end_clr = 1'b1;
            state_nxt = ST_IDLE;
          end else if (cur.pause) begin
            stop_nxt = 1'b1;
            ret_nxt = ST_RUN;
            state_nxt = ST_PAUSED;
          end else if (end_r && opt_r) begin
            abort_nxt = 1'b1;
            end_clr = 1'b1;
            state_nxt = ST_FETCH;
          end else if (blk_done) begin
            end_clr = 1'b1;
            state_nxt = cur.single_block ? ST_IDLE : ST_FETCH;
          end else if (ed_fall.cycle_start) begin
            pend_set = 1'b1;
          end
        end
        ST_AUX_WAIT: begin
          if (!cur.auto_mode) begin
            stop_nxt = 1'b1;
            state_nxt = ST_DECEL;
          end else if (cur.forced_end) begin
            abort_nxt = 1'b1;
            aux_clear = 1'b1;
            end_clr = 1'b1;
            state_nxt = ST_IDLE;
          end else if (cur.pause) begin
            ret_nxt = ST_AUX_WAIT;
            state_nxt = ST_PAUSED;
          end else if (end_r && opt_r) begin
            aux_clear = 1'b1;
            end_clr = 1'b1;
            state_nxt = ST_FETCH;
          end else if (ed_fall.code_reset) begin
            aux_clear = 1'b1;
            end_clr = 1'b1;
            if (cur.cycle_start && !cur.single_block) begin
              state_nxt = ST_FETCH;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_PAUSED: begin
          if (!cur.auto_mode) begin
            stop_nxt = 1'b1;
            state_nxt = ST_DECEL;
          end else if (resume_ok) begin
            go_nxt = (ret_r == ST_RUN);
            state_nxt = ret_r;
          end
        end
        ST_DECEL: begin
          if (axes_at_rest) begin
            state_nxt = ST_MANUAL;
          end
        end
        ST_MANUAL: begin
          if (cur.auto_mode) begin
            state_nxt = ST_IDLE;
          end else if (ed_rise.origin) begin
            busy_set = 1'b1;
            state_nxt = ST_ORIGIN;
          end
        end
        ST_ORIGIN: begin
          if (cur.auto_mode) begin
            stop_nxt = 1'b1;
            busy_clr = 1'b1;
            state_nxt = ST_IDLE;
          end else if (origin_done) begin
            busy_clr = 1'b1;
            state_nxt = ST_MANUAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      ret_r <= ST_FETCH;
    end else begin
      state_r <= state_nxt;
      ret_r <= ret_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      take_r <= 1'b0;
      go_r <= 1'b0;
      abort_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      take_r <= take_nxt;
      go_r <= go_nxt;
      abort_r <= abort_nxt;
      stop_r <= stop_nxt;
    end
  end

  // The code is never touched by a mode change, only by its own handshake,
  // a forced end, an error in fetch or run, or an optional end cancel.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_r <= AUX_RESET;
      aux_valid_r <= 1'b0;
    end else if (aux_load) begin
      aux_r <= blk.code;
      aux_valid_r <= 1'b1;
    end else if (aux_clear) begin
      aux_r <= AUX_RESET;
      aux_valid_r <= 1'b0;
    end
  end

  // A fault in the same cycle as the reset edge stays flagged.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else if (task_fault) begin
      err_r <= 1'b1;
    end else if (eval && ed_rise.err_reset) begin
      err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      skip_r <= 1'b0;
      end_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (skip_set) begin
        skip_r <= 1'b1;
      end else if (skip_clr || state_nxt == ST_IDLE) begin
        skip_r <= 1'b0;
      end
      if (end_set) begin
        end_r <= 1'b1;
      end else if (end_clr) begin
        end_r <= 1'b0;
      end
      if (pend_set) begin
        pend_r <= 1'b1;
      end else if (pend_clr) begin
        pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
    end else if (busy_set) begin
      busy_r <= 1'b1;
    end else if (busy_clr) begin
      busy_r <= 1'b0;
    end
  end

  // Jog is refused while the axes still decelerate.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      manual_r <= 1'b0;
      jog_r <= 1'b0;
      running_r <= 1'b0;
    end else begin
      manual_r <= (state_nxt == ST_MANUAL);
      jog_r <= (state_nxt == ST_MANUAL) && cur.jog;
      running_r <= (state_nxt == ST_FETCH) || (state_nxt == ST_RUN) ||
                   (state_nxt == ST_AUX_WAIT);
    end
  end

  assign rdata = rdata_r;
  assign blk_take = take_r;
  assign blk_go = go_r;
  assign blk_abort = abort_r;
  assign axis_stop = stop_r;
  assign aux_code = aux_r;
  assign aux_valid = aux_valid_r;
  assign busy = busy_r;
  assign manual_flag = manual_r;
  assign jog_enable = jog_r;
  assign running = running_r;
endmodule

//--- bench/run_ctrl_checker.sv
`timescale 1ns/1ps
module run_ctrl_checker #(
  parameter int CYCLE_LEN = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [run_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [run_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic axes_at_rest,
  input wire logic blk_go,
  input wire logic blk_abort,
  input wire logic axis_stop,
  input wire logic aux_valid,
  input wire logic busy,
  input wire logic manual_flag,
  input wire logic jog_enable,
  input wire logic running
);
  import run_ctrl_pkg::*;
  // Past this age a held bit has surely been seen by an evaluation.
  localparam int HOLD = 2 * CYCLE_LEN + 2;
  logic [CTRL_W-1:0] sh_r;
  logic [7:0] fe_r, pz_r, cr_r;
  function automatic logic [7:0] age(input logic on, input logic [7:0] n);
    return !on ? 8'h00 : (n == 8'hFF ? n : n + 8'h01);
  endfunction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_r <= CTRL_RESET;
    end else if (wr && addr == ADDR_CTRL) begin
      sh_r <= wdata[CTRL_W-1:0];
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fe_r <= 8'h00;
      pz_r <= 8'h00;
      cr_r <= 8'h00;
    end else begin
      fe_r <= age(sh_r[CTRL_FORCED_END], fe_r);
      pz_r <= age(sh_r[CTRL_PAUSE], pz_r);
      cr_r <= age(sh_r[CTRL_CODE_RESET], cr_r);
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  go_spacing_a: assert property (blk_go |=> !blk_go [*3])
    else $error("blk_go twice in one control cycle");
  end_held_a: assert property (fe_r > HOLD |-> !blk_go)
    else $error("blk_go while forced end held");
  pause_held_a: assert property (pz_r > HOLD |-> !blk_go)
    else $error("blk_go while pause held");
  code_skip_a: assert property (cr_r > HOLD |-> !$rose(aux_valid))
    else $error("aux code driven while code reset held");
  abort_clear_a: assert property (blk_abort |-> ##[0:1] !aux_valid)
    else $error("aux code kept after abort");
  run_manual_a: assert property (running |-> !manual_flag)
    else $error("manual flag while running");
  busy_run_a: assert property (busy |-> !running)
    else $error("busy while running");
  decel_low_a: assert property (axis_stop |=> !manual_flag [*2])
    else $error("manual flag during decel");
  rest_first_a: assert property ($rose(manual_flag) |-> $past(axes_at_rest))
    else $error("manual flag before axes at rest");
  jog_gate_a: assert property (
      jog_enable |-> manual_flag || $past(manual_flag))
    else $error("jog enabled outside manual");
endmodule

bind run_ctrl run_ctrl_checker #(.CYCLE_LEN(CYCLE_LEN)) chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
  .axes_at_rest(axes_at_rest), .blk_go(blk_go), .blk_abort(blk_abort),
  .axis_stop(axis_stop), .aux_valid(aux_valid), .busy(busy),
  .manual_flag(manual_flag), .jog_enable(jog_enable), .running(running)
);

//--- bench/prog_feed.sv
`timescale 1ns/1ps
module prog_feed (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic blk_take,
  input wire logic blk_go,
  input wire logic blk_abort,
  output run_ctrl_pkg::blk_in_t blk,
  output logic blk_done
);
  import run_ctrl_pkg::*;
  blk_in_t prog[$];
  logic [AUX_W-1:0] last_r;
  logic act_r;
  task automatic add(input blk_kind_t k, input logic [AUX_W-1:0] cd);
    prog.push_back({1'b1, k, cd});
  endtask
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog.delete();
      blk <= '0;
      blk_done <= 1'b0;
      act_r <= 1'b0;
      last_r <= 8'h00;
    end else begin
      if (blk_take && prog.size() > 0) begin
        last_r <= prog[0].code;
        void'(prog.pop_front());
      end
      // An empty feed shows no stale code: the code lines are inverted.
      blk <= prog.size() > 0 ? prog[0] :
             blk_in_t'({1'b0, BLK_PROGRAM_END, ~last_r});
      // Motion ends only when the bench lets it, so runs can be held open.
      if (blk_go || blk_take || blk_abort) begin
        act_r <= blk_go;
        blk_done <= 1'b0;
      end else begin
        blk_done <= act_r && !stall;
      end
    end
  end
endmodule

//--- bench/motion_program_run_control_test.sv
`timescale 1ns/1ps
module motion_program_run_control_test;
  import run_ctrl_pkg::*;
  localparam int CL = 4;
  localparam logic [CTRL_W-1:0] CS = 9'h001 << CTRL_CYCLE_START;
  localparam logic [CTRL_W-1:0] FE = 9'h001 << CTRL_FORCED_END;
  localparam logic [CTRL_W-1:0] PZ = 9'h001 << CTRL_PAUSE;
  localparam logic [CTRL_W-1:0] AU = 9'h001 << CTRL_AUTO_MODE;
  localparam logic [CTRL_W-1:0] CR = 9'h001 << CTRL_CODE_RESET;
  localparam logic [CTRL_W-1:0] ER = 9'h001 << CTRL_ERR_RESET;
  localparam logic [CTRL_W-1:0] OG = 9'h001 << CTRL_ORIGIN;
  localparam logic [CTRL_W-1:0] JG = 9'h001 << CTRL_JOG;
  localparam logic [CTRL_W-1:0] SB = 9'h001 << CTRL_SINGLE_BLOCK;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [DATA_W-1:0] rdata, d;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic opt_in = 1'b0;
  logic axes_at_rest = 1'b1;
  logic origin_done = 1'b0;
  logic task_fault = 1'b0;
  logic stall = 1'b1;
  logic blk_done, blk_take, blk_go, blk_abort, axis_stop, aux_valid;
  logic busy, manual_flag, jog_enable, running;
  logic [AUX_W-1:0] aux_code, code;
  logic [CTRL_W-1:0] c = CTRL_RESET;
  blk_in_t blk;
  int n_fail = 0;
  int tests_run = 0;
  int n_go, n_ab, n_stop;
  always #12.5 clk = ~clk;
  run_ctrl #(.CYCLE_LEN(CL)) uut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .opt_in(opt_in), .blk(blk), .blk_done(blk_done),
    .axes_at_rest(axes_at_rest), .origin_done(origin_done),
    .task_fault(task_fault), .blk_take(blk_take), .blk_go(blk_go),
    .blk_abort(blk_abort), .axis_stop(axis_stop), .aux_code(aux_code),
    .aux_valid(aux_valid), .busy(busy), .manual_flag(manual_flag),
    .jog_enable(jog_enable), .running(running)
  );
  prog_feed feed (
    .clk(clk), .rstn(rstn), .stall(stall), .blk_take(blk_take),
    .blk_go(blk_go), .blk_abort(blk_abort), .blk(blk), .blk_done(blk_done)
  );
  always @(posedge clk) begin
    if (blk_go) n_go++;
    if (blk_abort) n_ab++;
    if (axis_stop) n_stop++;
  end
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [DATA_W-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic clr();
    n_go = 0;
    n_ab = 0;
    n_stop = 0;
  endtask
  task automatic idle(input int n);
    repeat (n * CL) @(posedge clk);
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic sbit(input string n, input int b, input logic v);
    rreg(ADDR_STATUS, d);
    chk(n, v, d[b]);
  endtask
  // Each change is held four control cycles so no evaluation misses it.
  task automatic put(input logic [CTRL_W-1:0] m, input logic v);
    c = v ? (c | m) : (c & ~m);
    wreg(ADDR_CTRL, DATA_W'(c));
    idle(4);
  endtask
  task automatic toggle();
    put(CS, 1'b0);
    put(CS, 1'b1);
  endtask
  task automatic setup(input blk_kind_t k0, k1, input logic o);
    rstn <= 1'b0;
    opt_in <= o;
    stall <= 1'b1;
    c = CTRL_RESET;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // Blocks are queued only once the feed has left reset.
    put(AU, 1'b1);
    code = AUX_W'($urandom) | 8'h01;
    feed.add(k0, code);
    feed.add(k1, code);
    feed.add(BLK_MOTION, code);
    clr();
  endtask
  initial begin
    void'($urandom(93));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rreg(ADDR_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    rreg(4'hC, d);
    chk("unmapped read", 32'h0, d);
    put(AU, 1'b1);
    repeat (6) feed.add(BLK_MOTION, 8'h00);
    put(CS | FE, 1'b1);
    chk("start with end", 0, running);
    put(FE, 1'b0);
    chk("start held", 0, running);
    toggle();
    chk("start again", 1, running);
    clr();
    put(FE, 1'b1);
    chk("abort", 1, n_ab);
    chk("halted", 0, running);
    toggle();
    chk("end held", 0, running);
    put(FE, 1'b0);
    toggle();
    chk("resumed", 1, running);
    clr();
    put(FE | PZ, 1'b1);
    chk("end beats pause", 1, n_ab);
    sbit("not paused", STAT_PAUSED, 1'b0);
    put(FE | PZ | CS, 1'b0);
    put(PZ, 1'b1);
    clr();
    put(CS | FE, 1'b1);
    chk("no start", 0, n_go);
    chk("no abort", 0, n_ab);
    put(PZ | FE, 1'b0);
    toggle();
    clr();
    put(PZ, 1'b1);
    sbit("paused", STAT_PAUSED, 1'b1);
    put(FE, 1'b1);
    chk("end ignored", 0, n_ab);
    put(FE | PZ, 1'b0);
    toggle();
    chk("continued", 1, running);
    setup(BLK_AUX_CODE, BLK_MOTION, 1'b0);
    put(CR, 1'b1);
    put(CS, 1'b1);
    chk("aux skipped", 0, aux_valid);
    chk("went on", 1, n_go);
    setup(BLK_AUX_CODE, BLK_MOTION, 1'b0);
    put(CS, 1'b1);
    chk("aux code", code, aux_code);
    toggle();
    sbit("aux wait", STAT_AUX_WAIT, 1'b1);
    put(PZ | CR, 1'b1);
    chk("aux paused", 1, aux_valid);
    put(PZ | CR, 1'b0);
    toggle();
    chk("aux again", code, aux_code);
    put(CR, 1'b1);
    put(CR, 1'b0);
    chk("aux cleared", 0, aux_valid);
    chk("next block", 1, feed.prog.size());
    setup(BLK_AUX_CODE, BLK_MOTION, 1'b0);
    put(CS, 1'b1);
    put(FE | CR, 1'b1);
    chk("aux dropped", 0, aux_valid);
    chk("wait cancelled", 1, n_ab);
    put(CR, 1'b0);
    chk("no restart", 0, running);
    setup(BLK_OPTIONAL_SKIP_FUNCTION, BLK_MOTION, 1'b1);
    put(CS, 1'b1);
    idle(4);
    chk("skipped", 0, feed.prog.size());
    setup(BLK_OPTIONAL_PROGRAM_STOP_FUNCTION, BLK_MOTION, 1'b1);
    put(CS, 1'b1);
    idle(4);
    chk("opt stop", 0, running);
    chk("opt stop left", 2, feed.prog.size());
    setup(BLK_OPTIONAL_END_FUNCTION, BLK_WAITING_COMMAND, 1'b1);
    put(CS, 1'b1);
    idle(4);
    chk("wait dropped", 0, feed.prog.size());
    setup(BLK_AUX_CODE, BLK_MOTION, 1'b0);
    put(CS, 1'b1);
    axes_at_rest <= 1'b0;
    put(AU | JG, 1'b0);
    put(JG, 1'b1);
    chk("manual halt", 0, running);
    chk("decel", 1, n_stop);
    chk("flag low", 0, manual_flag);
    chk("jog refused", 0, jog_enable);
    chk("aux kept", code, aux_code);
    axes_at_rest <= 1'b1;
    idle(4);
    chk("jog taken", 1, jog_enable);
    put(JG, 1'b0);
    put(OG, 1'b1);
    chk("busy", 1, busy);
    clr();
    put(AU, 1'b1);
    chk("busy low", 0, busy);
    chk("axes stopped", 1, n_stop);
    setup(BLK_MOTION, BLK_MOTION, 1'b0);
    put(CS, 1'b1);
    put(CS, 1'b0);
    stall <= 1'b0;
    put(FE, 1'b1);
    chk("start fall wins", 0, n_ab);
    chk("halted at end", 0, running);
    put(FE, 1'b0);
    put(CS, 1'b1);
    chk("resumed again", 1, running);
    idle(8);
    chk("drained", 3, n_go);
    put(FE, 1'b1);
    chk("between cancel", 1, n_ab);
    chk("between halt", 0, running);
    setup(BLK_MOTION, BLK_MOTION, 1'b0);
    put(SB | CS, 1'b1);
    put(FE, 1'b1);
    put(FE | CS, 1'b0);
    stall <= 1'b0;
    put(CS, 1'b1);
    chk("single next", 2, n_go);
    chk("single stop", 0, running);
    chk("single left", 1, feed.prog.size());
    setup(BLK_MOTION, BLK_MOTION, 1'b0);
    task_fault <= 1'b1;
    @(posedge clk);
    task_fault <= 1'b0;
    sbit("error", STAT_ERROR, 1'b1);
    put(CS, 1'b1);
    chk("error blocks", 0, running);
    put(CS, 1'b0);
    put(ER | CS, 1'b1);
    sbit("error cleared", STAT_ERROR, 1'b0);
    chk("restarted", 1, running);
    close_out();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule
